/* lkw_pkg.sv */
// shared constants and types of the lookahead word adder
package lkw_pkg;

	localparam int LKW_NPOS   = 39;
	localparam int LKW_NGRP   = 7;
	localparam int LKW_DATA_W = 35;
	localparam int LKW_WORD_W = 36;
	localparam int LKW_ACC_W  = 37;
	localparam int LKW_SC_W   = 8;

	// position index, low order first: 35..9 at 0..26, then guards, 8..1, P, Q
	localparam int LKW_IDX_B9    = 26;
	localparam int LKW_IDX_GLO   = 27;
	localparam int LKW_IDX_GHI   = 28;
	localparam int LKW_IDX_B8    = 29;
	localparam int LKW_IDX_B1    = 36;
	localparam int LKW_IDX_OVF_P = 37;
	localparam int LKW_IDX_OVF_Q = 38;

	// group placement; the sixth group instance starts above float_guard_high
	localparam int LKW_GRP_LO [LKW_NGRP] = '{0, 5, 10, 16, 22, 29, 33};
	localparam int LKW_GRP_N  [LKW_NGRP] = '{5, 5, 6, 6, 6, 4, 6};
	localparam int LKW_GRP_GUARD = 5;

	// clock rate and settle budget of the combinational path
	localparam int LKW_CLK_MHZ   = 25;
	localparam int LKW_CLK_NS    = 1000 / LKW_CLK_MHZ;
	localparam int LKW_SETTLE_NS = 40;
	localparam int LKW_SETTLE_CYC = (LKW_SETTLE_NS + LKW_CLK_NS - 1) / LKW_CLK_NS;

	localparam logic [LKW_ACC_W-1:0]  LKW_ACC_RST  = 37'h0;
	localparam logic [LKW_WORD_W-1:0] LKW_WORD_RST = 36'h0;
	localparam logic [LKW_SC_W-1:0]   LKW_SC_RST   = 8'h0;

	typedef enum logic [2:0] {
		LKW_DST_NONE,
		LKW_DST_ACC,
		LKW_DST_MQ,
		LKW_DST_MEM,
		LKW_DST_SC
	} lkw_dst_t;

	typedef struct packed {
		logic     gate_mem;
		logic     comp_mem;
		logic     gate_acc;
		logic     comp_acc;
		logic     carry_in;
		logic     float_op;
		logic     sign_in;
		lkw_dst_t dst;
	} lkw_ctl_t;

	typedef struct packed {
		logic                  valid;
		logic [LKW_WORD_W-1:0] data;
	} lkw_load_t;

	typedef struct packed {
		logic q_carry;
		logic overflow;
	} lkw_flags_t;

endpackage

/* lkw_group.sv */
// one lookahead group of adder positions
`timescale 1ns/1ps
module lkw_group
	import lkw_pkg::*;
#(
	parameter int N       = 5,
	parameter bit XOR_TOP = 1'b0
) (
	input  wire logic [N-1:0] a,
	input  wire logic [N-1:0] b,
	input  wire logic         cin,
	output logic      [N-1:0] sum,
	output logic      [N-1:0] cvec,
	output logic      [N-1:0] gvec,
	output logic      [N-1:0] pvec,
	output logic              any_gen,
	output logic              gen_or_prop,
	output logic              grp_gen
);

	// elaboration check: the flat carry terms are sized for small groups only
	generate
		if (N < 2 || N > 8) begin : g_bad_n
			$error("lkw_group: N out of range");
		end
	endgenerate

	logic [N-1:0] p;
	logic [N-1:0] g;
	logic [N-1:0] x;
	logic [N-1:0] xn;

	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_pos
			assign p[i]  = a[i] | b[i];
			assign g[i]  = a[i] & b[i];
			assign x[i]  = p[i] & ~g[i];
			assign xn[i] = ~x[i];
			assign sum[i] = (x[i] & ~cvec[i]) | (xn[i] & cvec[i]);
		end
	endgenerate

	assign gvec = g;
	assign pvec = p;

	// every carry is a flat sum of products of lower positions and cin
	always_comb begin
		logic t;
		logic c;
		t = 1'b0;
		c = 1'b0;
		for (int k = 0; k < N; k++) begin
			c = cin;
			for (int m = 0; m < k; m++) begin
				c = c & ((XOR_TOP && k == N - 1) ? x[m] : p[m]);
			end
			for (int j = 0; j < k; j++) begin
				t = g[j];
				for (int m = j + 1; m < k; m++) begin
					t = t & ((XOR_TOP && k == N - 1) ? x[m] : p[m]);
				end
				c = c | t;
			end
			cvec[k] = c;
		end
	end

	// group terms: any generate, generate or propagate, internal generate
	always_comb begin
		logic t;
		t = 1'b0;
		any_gen     = |g;
		gen_or_prop = &p;
		grp_gen     = 1'b0;
		for (int j = 0; j < N; j++) begin
			t = g[j];
			for (int m = j + 1; m < N; m++) begin
				t = t & p[m];
			end
			grp_gen = grp_gen | t;
			if (j >= 1) begin
				gen_or_prop = gen_or_prop | t;
			end
		end
	end

endmodule

/* lkw_adder.sv */
// lookahead word adder with operand gating and destination registers
// Overview of operation
// - adder has 39 positions: two overflow, data 1-35, two float guards
// - two positions above bit 1 catch overflow of arithmetic or logic
// - guard positions between bits 8 and 9 add only in float operations
// - each position takes memory and accumulator bits, true or complemented
// - sum goes to accumulator, mq, memory word or shift count per operation
// - propagate is set when either operand bit is one
// - generate is set when both operand bits are one
// - exclusive-or is set when exactly one bit is one; complement also formed
// - sum is xor without carry, or not-xor with carry
// - carry into bit 34 is generate 35 or propagate 35 with carry in
// - carry into bit 31 uses xor terms instead of propagate terms
// - bit 30 takes its carry only from group lookahead
// - carries inside a group come straight from operands and group carry
// - seven groups: 35-31,30-26,25-20,19-14,13-9P,9Q+8-5,4-1+P+Q
// - upper guard feeds the lookahead terms of the sixth group
// - each group carry is decided from all lower groups at once
// - group one carries out on internal generate or carry in propagated
// - groups two to seven give any-generate and generate-or-propagate
`timescale 1ns/1ps
module lkw_adder
	import lkw_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  nrst,
	input  wire lkw_ctl_t              ctl,
	input  wire lkw_load_t             mem_load,
	output logic      [LKW_ACC_W-1:0]  arith_holding_reg,
	output logic      [LKW_WORD_W-1:0] mult_quot_reg,
	output logic      [LKW_WORD_W-1:0] memory_word_reg,
	output logic      [LKW_SC_W-1:0]   shift_count_reg,
	output lkw_flags_t                 flags_reg
);

	logic rst_meta_reg;
	logic rst_n_sync;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta_reg <= 1'b0;
			rst_n_sync   <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n_sync   <= rst_meta_reg;
		end
	end

	// operand position vectors, low order first
	logic [LKW_NPOS-1:0] mem_pos;
	logic [LKW_NPOS-1:0] acc_pos;
	logic [LKW_NPOS-1:0] op_a;
	logic [LKW_NPOS-1:0] op_b;
	logic [LKW_NPOS-1:0] sum;
	logic [LKW_NPOS-1:0] cin_pos;

	function automatic logic [LKW_NPOS-1:0] to_pos(
		input logic [1:0]            ovf,
		input logic [LKW_DATA_W-1:0] data
	);
		logic [LKW_NPOS-1:0] v;
		v = '0;
		v[LKW_IDX_B9:0]            = data[LKW_IDX_B9:0];
		v[LKW_IDX_B1:LKW_IDX_B8]   = data[LKW_DATA_W-1:LKW_IDX_B9+1];
		v[LKW_IDX_OVF_Q:LKW_IDX_OVF_P] = ovf;
		return v;
	endfunction

	function automatic logic [LKW_DATA_W-1:0] data_of(input logic [LKW_NPOS-1:0] v);
		return {v[LKW_IDX_B1:LKW_IDX_B8], v[LKW_IDX_B9:0]};
	endfunction

	assign mem_pos = to_pos(2'b00, memory_word_reg[LKW_DATA_W-1:0]);
	assign acc_pos = to_pos(arith_holding_reg[LKW_ACC_W-1:LKW_DATA_W],
		arith_holding_reg[LKW_DATA_W-1:0]);

	// operand gating; outside float the guards are held at pure propagate
	always_comb begin
		op_a = ctl.gate_mem ? (ctl.comp_mem ? ~mem_pos : mem_pos) : '0;
		op_b = ctl.gate_acc ? (ctl.comp_acc ? ~acc_pos : acc_pos) : '0;
		if (!ctl.float_op) begin
			op_a[LKW_IDX_GHI:LKW_IDX_GLO] = 2'b11;
			op_b[LKW_IDX_GHI:LKW_IDX_GLO] = 2'b00;
		end
	end

	logic [LKW_NGRP-1:0] any_gen;
	logic [LKW_NGRP-1:0] gen_or_prop;
	logic [LKW_NGRP-1:0] grp_gen;
	logic [LKW_NGRP-1:0] grp_cin;
	logic [LKW_NGRP-1:0] inst_cin;
	logic [LKW_NGRP-1:0] gen_t;
	logic [LKW_NGRP-1:0] prop_t;
	logic [LKW_NGRP:0]   grp_carry;
	logic [LKW_NPOS-1:0] gvec;
	logic [LKW_NPOS-1:0] pvec;

	// float_guard_high stands outside the groups
	logic ghi_p;
	logic ghi_g;
	logic ghi_x;

	assign ghi_p = op_a[LKW_IDX_GHI] | op_b[LKW_IDX_GHI];
	assign ghi_g = op_a[LKW_IDX_GHI] & op_b[LKW_IDX_GHI];
	assign ghi_x = ghi_p & ~ghi_g;
	assign cin_pos[LKW_IDX_GHI] = grp_cin[LKW_GRP_GUARD];
	assign sum[LKW_IDX_GHI] = ghi_x ^ grp_cin[LKW_GRP_GUARD];
	assign gvec[LKW_IDX_GHI] = ghi_g;
	assign pvec[LKW_IDX_GHI] = ghi_p;

	genvar gi;
	generate
		for (gi = 0; gi < LKW_NGRP; gi++) begin : g_grp
			localparam int LO = LKW_GRP_LO[gi];
			localparam int NN = LKW_GRP_N[gi];
			lkw_group #(
				.N       (NN),
				.XOR_TOP (gi == 0)
			) u_grp (
				.a           (op_a[LO+NN-1:LO]),
				.b           (op_b[LO+NN-1:LO]),
				.cin         (inst_cin[gi]),
				.sum         (sum[LO+NN-1:LO]),
				.cvec        (cin_pos[LO+NN-1:LO]),
				.gvec        (gvec[LO+NN-1:LO]),
				.pvec        (pvec[LO+NN-1:LO]),
				.any_gen     (any_gen[gi]),
				.gen_or_prop (gen_or_prop[gi]),
				.grp_gen     (grp_gen[gi])
			);
			if (gi == LKW_GRP_GUARD) begin : g_ghi
				assign inst_cin[gi] = ghi_g | (ghi_p & grp_cin[gi]);
				assign gen_t[gi]  = (any_gen[gi] | ghi_g) & gen_or_prop[gi];
				assign prop_t[gi] = gen_or_prop[gi] & ghi_p;
			end else if (gi == 0) begin : g_first
				assign inst_cin[gi] = grp_cin[gi];
				assign gen_t[gi]  = grp_gen[gi] | (ctl.carry_in & &pvec[4:0]);
				assign prop_t[gi] = 1'b0;
			end else begin : g_rest
				assign inst_cin[gi] = grp_cin[gi];
				assign gen_t[gi]  = any_gen[gi] & gen_or_prop[gi];
				assign prop_t[gi] = gen_or_prop[gi];
			end
		end
	endgenerate

	// carry into every group from all lower group terms at once
	function automatic logic [LKW_NGRP:0] grp_lookahead(
		input logic                cin,
		input logic [LKW_NGRP-1:0] gen,
		input logic [LKW_NGRP-1:0] prop
	);
		logic [LKW_NGRP:0] c;
		logic t;
		c = '0;
		t = 1'b0;
		c[0] = cin;
		for (int k = 1; k <= LKW_NGRP; k++) begin
			for (int j = 0; j < k; j++) begin
				t = gen[j];
				for (int m = j + 1; m < k; m++) begin
					t = t & prop[m];
				end
				c[k] = c[k] | t;
			end
		end
		return c;
	endfunction

	assign grp_carry = grp_lookahead(ctl.carry_in, gen_t, prop_t);
	assign grp_cin   = grp_carry[LKW_NGRP-1:0];

	// capture of the settled sum by the selected destination
	logic [LKW_DATA_W-1:0] sum_data;

	assign sum_data = data_of(sum);

	always_ff @(posedge clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			arith_holding_reg <= LKW_ACC_RST;
		end else if (ctl.dst == LKW_DST_ACC) begin
			arith_holding_reg <= {sum[LKW_IDX_OVF_Q:LKW_IDX_OVF_P], sum_data};
		end
	end

	always_ff @(posedge clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			mult_quot_reg <= LKW_WORD_RST;
		end else if (ctl.dst == LKW_DST_MQ) begin
			mult_quot_reg <= {ctl.sign_in, sum_data};
		end
	end

	always_ff @(posedge clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			memory_word_reg <= LKW_WORD_RST;
		end else if (mem_load.valid) begin
			memory_word_reg <= mem_load.data;
		end else if (ctl.dst == LKW_DST_MEM) begin
			memory_word_reg <= {ctl.sign_in, sum_data};
		end
	end

	always_ff @(posedge clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			shift_count_reg <= LKW_SC_RST;
		end else if (ctl.dst == LKW_DST_SC) begin
			shift_count_reg <= sum[LKW_IDX_B1:LKW_IDX_B8];
		end
	end

	always_ff @(posedge clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			flags_reg <= '0;
		end else if (ctl.dst != LKW_DST_NONE) begin
			flags_reg.q_carry  <= grp_carry[LKW_NGRP];
			flags_reg.overflow <= sum[LKW_IDX_OVF_Q] | sum[LKW_IDX_OVF_P];
		end
	end

	// reference sum over the non-guard positions
	logic [LKW_ACC_W-1:0] ref_a;
	logic [LKW_ACC_W-1:0] ref_b;
	logic [LKW_ACC_W:0]   ref_sum;
	logic [LKW_ACC_W-1:0] sum_ng;
	logic [5:0]           ref_g1;
	logic [4:0]           ref_c31;
	logic [5:0]           ref_g2;

	assign ref_a   = {op_a[LKW_IDX_OVF_Q:LKW_IDX_B8], op_a[LKW_IDX_B9:0]};
	assign ref_b   = {op_b[LKW_IDX_OVF_Q:LKW_IDX_B8], op_b[LKW_IDX_B9:0]};
	assign ref_sum = {1'b0, ref_a} + {1'b0, ref_b} + {{LKW_ACC_W{1'b0}}, ctl.carry_in};
	assign sum_ng  = {sum[LKW_IDX_OVF_Q:LKW_IDX_B8], sum[LKW_IDX_B9:0]};
	assign ref_g1  = {1'b0, op_a[4:0]} + {1'b0, op_b[4:0]} + {5'h0, ctl.carry_in};
	assign ref_c31 = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]} + {4'h0, ctl.carry_in};
	assign ref_g2  = {1'b0, op_a[9:5]} + {1'b0, op_b[9:5]};

	AST_REF_SUM: assert property (@(posedge clk) disable iff (!rst_n_sync)
		!ctl.float_op |-> sum_ng == ref_sum[LKW_ACC_W-1:0]
			&& grp_carry[LKW_NGRP] == ref_sum[LKW_ACC_W])
		else $error("sum differs from reference");

	AST_GUARD_PASS: assert property (@(posedge clk) disable iff (!rst_n_sync)
		!ctl.float_op |-> cin_pos[LKW_IDX_B8] == cin_pos[LKW_IDX_GLO])
		else $error("guards disturb carry outside float");

	AST_PROP_GEN: assert property (@(posedge clk) disable iff (!rst_n_sync)
		pvec == (op_a | op_b) && gvec == (op_a & op_b))
		else $error("propagate or generate wrong");

	AST_C34: assert property (@(posedge clk) disable iff (!rst_n_sync)
		cin_pos[1] == (gvec[0] | (pvec[0] & ctl.carry_in)))
		else $error("carry into bit 34 wrong");

	AST_C31: assert property (@(posedge clk) disable iff (!rst_n_sync)
		cin_pos[4] == ref_c31[4])
		else $error("carry into bit 31 wrong");

	AST_C30: assert property (@(posedge clk) disable iff (!rst_n_sync)
		cin_pos[LKW_GRP_LO[1]] == ref_g1[5])
		else $error("carry into bit 30 wrong");

	AST_G1_OUT: assert property (@(posedge clk) disable iff (!rst_n_sync)
		grp_cin[1] == ref_g1[5])
		else $error("group one carry wrong");

	AST_G2_GEN: assert property (@(posedge clk) disable iff (!rst_n_sync)
		(any_gen[1] & gen_or_prop[1]) == ref_g2[5])
		else $error("group two generate terms wrong");

	AST_SUM_BIT: assert property (@(posedge clk) disable iff (!rst_n_sync)
		sum[0] == ((op_a[0] ^ op_b[0]) ^ ctl.carry_in))
		else $error("sum bit 35 wrong");

	AST_DEST_ACC: assert property (@(posedge clk) disable iff (!rst_n_sync)
		ctl.dst == LKW_DST_ACC |=> arith_holding_reg
			== $past({sum[LKW_IDX_OVF_Q:LKW_IDX_OVF_P], sum_data}))
		else $error("accumulator did not take sum");

	AST_DEST_SC: assert property (@(posedge clk) disable iff (!rst_n_sync)
		ctl.dst == LKW_DST_SC |=> shift_count_reg == $past(sum[LKW_IDX_B1:LKW_IDX_B8]))
		else $error("shift count did not take sum");

	AST_HOLD: assert property (@(posedge clk) disable iff (!rst_n_sync)
		ctl.dst == LKW_DST_NONE && !mem_load.valid |=> $stable(arith_holding_reg)
			&& $stable(mult_quot_reg) && $stable(memory_word_reg)
			&& $stable(shift_count_reg))
		else $error("register changed with no destination");

	AST_OVF_FLAG: assert property (@(posedge clk) disable iff (!rst_n_sync)
		ctl.dst == LKW_DST_ACC |=> flags_reg.overflow
			== (|arith_holding_reg[LKW_ACC_W-1:LKW_DATA_W]))
		else $error("overflow flag disagrees with accumulator");

	CVR_FLOAT: cover property (@(posedge clk) disable iff (!rst_n_sync)
		ctl.float_op && ctl.dst == LKW_DST_ACC);
	CVR_QCARRY: cover property (@(posedge clk) disable iff (!rst_n_sync)
		grp_carry[LKW_NGRP] && ctl.dst != LKW_DST_NONE);
	CVR_LONG_CARRY: cover property (@(posedge clk) disable iff (!rst_n_sync)
		ctl.carry_in && &pvec[LKW_IDX_B1:0] && !(|gvec));
	CVR_MEM_SC: cover property (@(posedge clk) disable iff (!rst_n_sync)
		ctl.dst == LKW_DST_MEM ##2 ctl.dst == LKW_DST_SC);

endmodule

/* lkw_seq_model.sv */
// sequencing model that presents operand control and memory loads to the adder
`timescale 1ns/1ps
module lkw_seq_model
	import lkw_pkg::*;
(
	input  wire logic clk,
	output lkw_ctl_t  ctl,
	output lkw_load_t mem_load
);
	initial begin
		ctl      = '0;
		mem_load = '0;
	end

	// one operation per call: presented for one edge, then withdrawn
	task automatic issue(input lkw_ctl_t c, input lkw_load_t l);
		@(posedge clk);
		ctl      <= c;
		mem_load <= l;
		@(posedge clk);
		ctl      <= '0;
		// released data lines show the inverse so stale data is never mistaken
		mem_load <= '{1'b0, ~l.data};
	endtask
endmodule

/* tb_top.sv */
// self-checking testbench of the lookahead word adder
`timescale 1ns/1ps
module tb_top
	import lkw_pkg::*;
;
	localparam int LIMIT = 3000;
	localparam lkw_load_t NL = '0;
	localparam logic [34:0] TA [12] = '{35'h7_ffff_ffff, 35'h0, 35'h1, 35'h0f, 35'h1f,
		35'h10, 35'h3ff, 35'h5_5555_5555, 35'h7_ffff_ffff, 35'h4_0000_0000,
		35'h0_07ff_ffff, 35'h0_0fff_f000};
	localparam logic [34:0] TB [12] = '{35'h0, 35'h0, 35'h1, 35'h1, 35'h0, 35'h10,
		35'h1, 35'h2_aaaa_aaaa, 35'h7_ffff_ffff, 35'h4_0000_0000, 35'h1, 35'h0_0000_1000};
	localparam bit TC [12] = '{1, 1, 0, 0, 1, 0, 0, 1, 0, 0, 0, 0};

	logic                  clk;
	logic                  nrst;
	lkw_ctl_t              ctl;
	lkw_load_t             mem_load;
	logic [LKW_ACC_W-1:0]  arith_holding_reg;
	logic [LKW_WORD_W-1:0] mult_quot_reg;
	logic [LKW_WORD_W-1:0] memory_word_reg;
	logic [LKW_SC_W-1:0]   shift_count_reg;
	lkw_flags_t            flags_reg;
	logic [36:0]           e_acc;
	logic [35:0]           e_mq;
	logic [35:0]           e_mem;
	logic [7:0]            e_sc;
	lkw_flags_t            e_flg;
	int                    num_errors;
	int                    n_tests;
	int                    cyc;

	lkw_adder lkw_adder_inst (
		.clk               (clk),
		.nrst              (nrst),
		.ctl               (ctl),
		.mem_load          (mem_load),
		.arith_holding_reg (arith_holding_reg),
		.mult_quot_reg     (mult_quot_reg),
		.memory_word_reg   (memory_word_reg),
		.shift_count_reg   (shift_count_reg),
		.flags_reg         (flags_reg)
	);

	lkw_seq_model lkw_seq_model_inst (
		.clk      (clk),
		.ctl      (ctl),
		.mem_load (mem_load)
	);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			num_errors++;
			give_verdict();
		end
	end

	task automatic chk(input logic ok, input string what);
		n_tests++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("BAD %0t %s", $time, what);
		end
	endtask

	function automatic lkw_ctl_t mk(input logic gm, cm, ga, ca, ci, fl, sg, input lkw_dst_t d);
		return '{gm, cm, ga, ca, ci, fl, sg, d};
	endfunction

	// reference sum: 37 positions plus carry out; guards stop bit 9's carry in float
	function automatic logic [37:0] calc(input lkw_ctl_t c);
		logic [36:0] a;
		logic [36:0] b;
		logic [27:0] lo;
		logic [10:0] hi;
		a = c.gate_mem ? {2'b00, e_mem[34:0]} : 37'h0;
		if (c.comp_mem) a = ~a;
		b = c.gate_acc ? e_acc : 37'h0;
		if (c.comp_acc) b = ~b;
		if (!c.float_op) return {1'b0, a} + {1'b0, b} + 38'(c.carry_in);
		lo = {1'b0, a[26:0]} + {1'b0, b[26:0]} + 28'(c.carry_in);
		hi = {1'b0, a[36:27]} + {1'b0, b[36:27]};
		return {hi, lo[26:0]};
	endfunction

	task automatic check_all();
		chk(arith_holding_reg === e_acc, "accumulator");
		chk(mult_quot_reg === e_mq, "mq");
		chk(memory_word_reg === e_mem, "memory word");
		chk(shift_count_reg === e_sc, "shift count");
		chk(flags_reg === e_flg, "flags");
	endtask

	task automatic op(input lkw_ctl_t c, input lkw_load_t l);
		logic [37:0] s;
		s = calc(c);
		case (c.dst)
			LKW_DST_ACC: e_acc = s[36:0];
			LKW_DST_MQ:  e_mq = {c.sign_in, s[34:0]};
			LKW_DST_MEM: e_mem = {c.sign_in, s[34:0]};
			LKW_DST_SC:  e_sc = s[34:27];
			default:     ;
		endcase
		if (c.dst != LKW_DST_NONE) e_flg = '{s[37], s[36] | s[35]};
		if (l.valid) e_mem = l.data;
		lkw_seq_model_inst.issue(c, l);
		#1;
		check_all();
	endtask

	task automatic add_case(input logic [34:0] a, b, input logic ci, fl, cm, ca);
		op(mk(0, 0, 0, 0, 0, 0, 0, LKW_DST_NONE), '{1'b1, {1'b0, b}});
		op(mk(1, 0, 0, 0, 0, 0, 0, LKW_DST_ACC), NL);
		op(mk(0, 0, 0, 0, 0, 0, 0, LKW_DST_NONE), '{1'b1, {1'b1, a}});
		op(mk(1, cm, 1, ca, ci, fl, 0, LKW_DST_ACC), NL);
	endtask

	task automatic do_reset();
		@(posedge clk);
		nrst <= 1'b0;
		@(posedge clk);
		#1;
		e_acc = '0;
		e_mq  = '0;
		e_mem = '0;
		e_sc  = '0;
		e_flg = '0;
		check_all();
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
	endtask

	task automatic s_route();
		op(mk(0, 0, 0, 0, 0, 0, 0, LKW_DST_NONE), '{1'b1, 36'h8_0123_4567});
		op(mk(1, 0, 0, 0, 0, 0, 0, LKW_DST_ACC), NL);
		op(mk(1, 0, 1, 0, 0, 0, 1, LKW_DST_MQ), NL);
		op(mk(1, 0, 1, 0, 1, 0, 0, LKW_DST_MEM), NL);
		op(mk(1, 0, 1, 0, 0, 0, 0, LKW_DST_SC), NL);
		op(mk(1, 0, 1, 0, 1, 0, 0, LKW_DST_NONE), NL);
		op(mk(1, 0, 1, 0, 0, 0, 0, LKW_DST_MEM), '{1'b1, 36'h1_2345_6789});
	endtask

	task automatic s_carry();
		for (int i = 0; i < 12; i++) begin
			add_case(TA[i], TB[i], TC[i], 1'b0, 1'b0, 1'b0);
		end
	endtask

	task automatic s_comp();
		add_case(35'h25, 35'h64, 1'b1, 1'b0, 1'b1, 1'b0);
		add_case(35'h64, 35'h25, 1'b1, 1'b0, 1'b1, 1'b0);
		add_case(35'h5, 35'h9, 1'b1, 1'b0, 1'b0, 1'b1);
		add_case(35'h0, 35'h0, 1'b0, 1'b0, 1'b1, 1'b1);
	endtask

	task automatic s_float();
		add_case(35'h0_07ff_ffff, 35'h1, 1'b0, 1'b1, 1'b0, 1'b0);
		add_case(35'h7_f800_0000, 35'h0_0800_0000, 1'b0, 1'b1, 1'b0, 1'b0);
		add_case(35'h0_07ff_fffe, 35'h1, 1'b1, 1'b1, 1'b0, 1'b0);
	endtask

	initial begin
		nrst       = 1'b0;
		num_errors = 0;
		n_tests    = 0;
		cyc        = 0;
		do_reset();
		s_route();
		s_carry();
		s_comp();
		s_float();
		do_reset();
		s_route();
		give_verdict();
	end
endmodule
